// file: shared/its_pkg.sv
// Constants and types of the two-wire slave with bus time-out
// Contract
// - Start is data fall while clock high
// - Start sets the bus-busy flag
// - Stop clears the bus-busy flag
// - Seven address bits arrive MSB first
// - Address match sets flag and raises interrupt
// - Eighth address bit stored as read/write flag
// - Matched address acknowledged low on ninth clock
// - Interrupt causes: match, byte done, time-out
// - Clock held low until data write/read
// - Data bytes eight bits, MSB first, after ack
// - Receiver drives acknowledge bit on ninth clock
// - Master not acknowledging releases data line
// - Byte done sets complete flag and interrupt
// - Time-out runs from match, cleared by clock fall
// - Time-out when count exceeds programmed period
// - Time-out stops counter, clears enable, flags
// - Time-out resets control-one to power-on values
// - Period is (select+1) times 32 slow clocks
// - Time-out flag set by hardware, cleared by zero
package its_pkg;

  // Register offsets on the software port
  localparam logic [2:0] OFF_SERIAL_CONTROL_ZERO = 3'h0;
  localparam logic [2:0] OFF_SERIAL_CONTROL_ONE  = 3'h1;
  localparam logic [2:0] OFF_SERIAL_DATA         = 3'h2;
  localparam logic [2:0] OFF_OWN_SLAVE_ADDRESS   = 3'h3;
  localparam logic [2:0] OFF_BUS_TIMEOUT_CONTROL = 3'h4;
  localparam logic [2:0] OFF_INTERRUPT_ENABLE    = 3'h5;

  // Field positions and codes
  localparam int        CTL0_MODE_LSB          = 5;
  localparam int        CTL0_UART_SELECT       = 4;
  localparam int        CTL0_ENABLE            = 1;
  localparam logic [2:0] MODE_TWO_WIRE_SLAVE   = 3'h6;
  localparam int        CTL1_HTX_BIT           = 4;
  localparam int        CTL1_TRANSMIT_ACKNOWLEDGE_BIT_BIT          = 3;
  localparam int        CTL1_WAKE_BIT          = 1;
  localparam int        TOC_ENABLE_BIT         = 7;
  localparam int        TOC_FLAG_BIT           = 6;

  // Power-on values
  localparam logic [7:0] CTL0_POR              = 8'he0;
  localparam logic [7:0] CTL1_POR              = 8'h81;
  localparam logic [7:0] TOC_POR               = 8'h00;

  // Timing: core clock and slow subsystem clock
  localparam int unsigned CORE_CLK_HZ          = 10000000;
  localparam int unsigned SUB_CLK_HZ           = 32768;
  localparam int unsigned SUB_PER_TICK         = 32;
  localparam int unsigned TO_TICK_CYCLES_DEF   =
    (CORE_CLK_HZ / SUB_CLK_HZ) * SUB_PER_TICK;

  // Second control/status register layout
  typedef struct packed {
    logic transfer_complete_flag;    // transfer_complete_flag
    logic address_match_flag;   // address_match_flag
    logic bus_busy_flag;    // bus_busy_flag
    logic transmit_direction_select;    // transmit_direction_select
    logic transmit_acknowledge_bit;   // transmit_acknowledge_bit
    logic slave_read_write_flag;    // slave_read_write_flag
    logic wake;   // address match wake-up enable
    logic received_acknowledge_flag;   // received_acknowledge_flag
  } its_ctl1_t;

  // Open-drain line drive
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } its_lines_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_HOLD, ST_RX, ST_RX_ACK,
    ST_TX, ST_TX_ACK
  } its_state_t;

endpackage

// file: hw/its_slave.sv
// Two-wire slave with register port and bus time-out
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module its_slave #(
  parameter int unsigned TICK_CYCLES = its_pkg::TO_TICK_CYCLES_DEF
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_b,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_scl_o,
  output logic            o_scl_oe,
  output logic            o_sda_o,
  output logic            o_sda_oe,
  output logic            o_irq
);
  import its_pkg::*;

  localparam int DW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  generate
    if (TICK_CYCLES < 1) begin : g_bad_tick
      $error("TICK_CYCLES must be at least one");
    end
  endgenerate

  // Synchroniser and edge stages
  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;

  // Registered state
  its_state_t  state, next_state;
  logic [3:0]  bit_cnt, next_bit_cnt;
  logic [7:0]  shift, next_shift;
  logic [7:0]  ctl0, next_ctl0;
  its_ctl1_t   ctl1, next_ctl1;
  logic [7:0]  data, next_data;
  logic [7:0]  own_addr, next_own_addr;
  logic [7:0]  toc, next_toc;
  logic        irq_en, next_irq_en;
  logic        to_run, next_to_run;
  logic [DW-1:0] to_div, next_to_div;
  logic [6:0]  to_ticks, next_to_ticks;
  its_lines_t  lines, next_lines;
  logic [7:0]  rdata, next_rdata;
  logic        irq, next_irq;

  // Line events seen on the synchronised pins, mode decode and time-out tick
  logic scl_rise, scl_fall, start_cond, stop_cond, active, tick, timeout;
  always_comb begin
    scl_rise   = scl_s2 & ~scl_d;
    scl_fall   = ~scl_s2 & scl_d;
    start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
    stop_cond  = scl_s2 & scl_d & ~sda_d & sda_s2;
    active     = ctl0[CTL0_ENABLE] & ~ctl0[CTL0_UART_SELECT] &
                 (ctl0[7:CTL0_MODE_LSB] == MODE_TWO_WIRE_SLAVE);
    tick       = (to_div == DW'(TICK_CYCLES - 1));
    timeout    = to_run & toc[TOC_ENABLE_BIT] &
                 (to_ticks > {1'b0, toc[5:0]});
  end

  // Next-state logic for bus, registers and time-out
  always_comb begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_shift    = shift;
    next_ctl0     = ctl0;
    next_ctl1     = ctl1;
    next_data     = data;
    next_own_addr = own_addr;
    next_toc      = toc;
    next_irq_en   = irq_en;
    next_to_run   = to_run;
    next_to_div   = to_div;
    next_to_ticks = to_ticks;
    next_lines    = lines;
    next_rdata    = 8'h00;
    next_irq      = 1'b0;

    // Register reads, answer one cycle later
    if (i_rd) begin
      case (i_addr)
        OFF_SERIAL_CONTROL_ZERO: next_rdata = ctl0;
        OFF_SERIAL_CONTROL_ONE:  next_rdata = ctl1;
        OFF_SERIAL_DATA:         next_rdata = data;
        OFF_OWN_SLAVE_ADDRESS:   next_rdata = own_addr;
        OFF_BUS_TIMEOUT_CONTROL: next_rdata = toc;
        OFF_INTERRUPT_ENABLE:    next_rdata = {7'h00, irq_en};
        default:                 next_rdata = 8'h00;
      endcase
    end

    // Register writes
    if (i_wr) begin
      case (i_addr)
        OFF_SERIAL_CONTROL_ZERO: next_ctl0 = i_wdata;
        OFF_SERIAL_CONTROL_ONE: begin
          next_ctl1.transmit_direction_select  = i_wdata[CTL1_HTX_BIT];
          next_ctl1.transmit_acknowledge_bit = i_wdata[CTL1_TRANSMIT_ACKNOWLEDGE_BIT_BIT];
          next_ctl1.wake = i_wdata[CTL1_WAKE_BIT];
        end
        OFF_SERIAL_DATA:       next_data = i_wdata;
        OFF_OWN_SLAVE_ADDRESS: next_own_addr = {1'b0, i_wdata[6:0]};
        OFF_BUS_TIMEOUT_CONTROL: begin
          next_toc[TOC_ENABLE_BIT] = i_wdata[TOC_ENABLE_BIT];
          next_toc[5:0]            = i_wdata[5:0];
          if (!i_wdata[TOC_FLAG_BIT]) begin
            next_toc[TOC_FLAG_BIT] = 1'b0;
          end
        end
        OFF_INTERRUPT_ENABLE:  next_irq_en = i_wdata[0];
        default: ;
      endcase
    end

    // Time-out divider and tick count
    if (to_run) begin
      next_to_div = tick ? '0 : to_div + DW'(1);
      if (tick && to_ticks != 7'h7f) begin
        next_to_ticks = to_ticks + 7'h01;
      end
    end
    if (scl_fall) begin
      next_to_div   = '0;
      next_to_ticks = 7'h00;
    end

    // Bus protocol
    case (state)
      ST_IDLE: ;
      ST_ADDR: begin
        if (scl_rise) begin
          next_shift   = {shift[6:0], sda_s2};
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == 4'h7) begin
            if (shift[6:0] == own_addr[6:0]) begin
              next_ctl1.address_match_flag = 1'b1;
              next_ctl1.slave_read_write_flag  = sda_s2;
              next_ctl1.transfer_complete_flag  = 1'b1;
              next_irq       = irq_en;
              next_to_run    = 1'b1;
              next_to_div    = '0;
              next_to_ticks  = 7'h00;
              next_state     = ST_ADDR_ACK;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
      end
      ST_ADDR_ACK: begin
        if (scl_fall) begin
          if (!lines.sda_oe) begin
            next_lines.sda_oe = 1'b1;
          end else begin
            next_lines.sda_oe = 1'b0;
            next_lines.scl_oe = 1'b1;
            next_state        = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        next_bit_cnt = 4'h0;
        if (ctl1.transmit_direction_select && i_wr && i_addr == OFF_SERIAL_DATA) begin
          next_shift        = i_wdata;
          next_lines.sda_oe = ~i_wdata[7];
          next_lines.scl_oe = 1'b0;
          next_ctl1.transfer_complete_flag     = 1'b0;
          next_ctl1.address_match_flag    = 1'b0;
          next_state        = ST_TX;
        end else if (!ctl1.transmit_direction_select && i_rd && i_addr == OFF_SERIAL_DATA) begin
          next_lines.scl_oe = 1'b0;
          next_ctl1.transfer_complete_flag     = 1'b0;
          next_ctl1.address_match_flag    = 1'b0;
          next_state        = ST_RX;
        end
      end
      ST_RX: begin
        if (scl_rise) begin
          next_shift   = {shift[6:0], sda_s2};
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == 4'h7) begin
            next_data     = {shift[6:0], sda_s2};
            next_ctl1.transfer_complete_flag = 1'b1;
            next_irq      = irq_en;
            next_state    = ST_RX_ACK;
          end
        end
      end
      ST_RX_ACK: begin
        if (scl_fall) begin
          if (bit_cnt == 4'h8) begin
            next_lines.sda_oe = ~ctl1.transmit_acknowledge_bit;
            next_bit_cnt      = 4'h9;
          end else begin
            next_lines.sda_oe = 1'b0;
            next_lines.scl_oe = 1'b1;
            next_state        = ST_HOLD;
          end
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          next_bit_cnt = bit_cnt + 4'h1;
          next_shift   = {shift[6:0], 1'b0};
          if (bit_cnt == 4'h7) begin
            next_lines.sda_oe = 1'b0;                // master acknowledges
            next_state        = ST_TX_ACK;
          end else begin
            next_lines.sda_oe = ~shift[6];
          end
        end
      end
      ST_TX_ACK: begin
        if (scl_rise) begin
          next_ctl1.received_acknowledge_flag = sda_s2;
          next_ctl1.transfer_complete_flag  = 1'b1;
          next_irq       = irq_en;
        end else if (scl_fall) begin
          if (!ctl1.received_acknowledge_flag) begin
            next_lines.scl_oe = 1'b1;
            next_state        = ST_HOLD;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase

    // Start and stop override the byte engine
    if (start_cond) begin
      next_ctl1.bus_busy_flag  = 1'b1;
      next_ctl1.transfer_complete_flag  = 1'b0;
      next_ctl1.address_match_flag = 1'b0;
      next_bit_cnt   = 4'h0;
      next_lines     = '0;
      next_state     = ST_ADDR;
    end else if (stop_cond) begin
      next_ctl1.bus_busy_flag = 1'b0;
      next_ctl1.transfer_complete_flag = 1'b1;
      next_to_run   = 1'b0;
      next_lines    = '0;
      next_state    = ST_IDLE;
    end

    // Time-out resets the bus logic and control-one
    if (timeout) begin
      next_to_run              = 1'b0;
      next_toc[TOC_ENABLE_BIT] = 1'b0;
      next_toc[TOC_FLAG_BIT]   = 1'b1;
      next_irq                 = irq_en;
      next_ctl1                = CTL1_POR;
      next_lines               = '0;
      next_state               = ST_IDLE;
    end

    // Interface switched off or not in slave mode
    if (!active) begin
      next_ctl1.transfer_complete_flag  = 1'b1;
      next_ctl1.address_match_flag = 1'b0;
      next_ctl1.bus_busy_flag  = 1'b0;
      next_ctl1.slave_read_write_flag  = 1'b0;
      next_ctl1.received_acknowledge_flag = 1'b1;
      next_to_run    = 1'b0;
      next_lines     = '0;
      next_state     = ST_IDLE;
    end
  end

  // State registers and pin synchronisers
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_s1   <= 1'b1;
      scl_s2   <= 1'b1;
      scl_d    <= 1'b1;
      sda_s1   <= 1'b1;
      sda_s2   <= 1'b1;
      sda_d    <= 1'b1;
      state    <= ST_IDLE;
      bit_cnt  <= 4'h0;
      shift    <= 8'h00;
      ctl0     <= CTL0_POR;
      ctl1     <= CTL1_POR;
      data     <= 8'h00;
      own_addr <= 8'h00;
      toc      <= TOC_POR;
      irq_en   <= 1'b0;
      to_run   <= 1'b0;
      to_div   <= '0;
      to_ticks <= 7'h00;
      lines    <= '0;
      rdata    <= 8'h00;
      irq      <= 1'b0;
      o_scl_o  <= 1'b0;
      o_sda_o  <= 1'b0;
    end else begin
      scl_s1   <= i_scl;
      scl_s2   <= scl_s1;
      scl_d    <= scl_s2;
      sda_s1   <= i_sda;
      sda_s2   <= sda_s1;
      sda_d    <= sda_s2;
      state    <= next_state;
      bit_cnt  <= next_bit_cnt;
      shift    <= next_shift;
      ctl0     <= next_ctl0;
      ctl1     <= next_ctl1;
      data     <= next_data;
      own_addr <= next_own_addr;
      toc      <= next_toc;
      irq_en   <= next_irq_en;
      to_run   <= next_to_run;
      to_div   <= next_to_div;
      to_ticks <= next_to_ticks;
      lines    <= next_lines;
      rdata    <= next_rdata;
      irq      <= next_irq;
      o_scl_o  <= 1'b0;
      o_sda_o  <= 1'b0;
    end
  end

  // Outputs straight from flops
  assign o_rdata  = rdata;
  assign o_scl_oe = lines.scl_oe;
  assign o_sda_oe = lines.sda_oe;
  assign o_irq    = irq;

endmodule // its_slave
`default_nettype wire

// file: verification/its_slave_properties.sv
// Port checker for the two-wire slave, bound into its_slave
`timescale 1ns/1ps
`default_nettype none
module its_slave_properties #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_scl,
  input wire logic o_scl_o,
  input wire logic o_scl_oe,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic o_irq
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  logic [3:0] sw_age;
  // Cycles since the last register access, saturating
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sw_age <= 4'hf;
    end else begin
      sw_age <= (i_wr || i_rd) ? 4'h0 : sw_age + 4'(sw_age != 4'hf);
    end
  end
  // Data line only moves while the clock is low
  property p_sda_rise;
    $rose(o_sda_oe) |-> !$past(i_scl, 2);
  endproperty
  a_sda_rise: assert property (p_sda_rise)
    else $error("data drive began with clock high");
  property p_sda_fall;
    $fell(o_sda_oe) |-> !$past(i_scl, 2);
  endproperty
  a_sda_fall: assert property (p_sda_fall)
    else $error("data release with clock high");
  // Stretch starts in a low phase, ends by software or time-out
  property p_scl_rise;
    $rose(o_scl_oe) |-> !$past(i_scl, 2);
  endproperty
  a_scl_rise: assert property (p_scl_rise)
    else $error("stretch began with clock high");
  property p_scl_fall;
    $fell(o_scl_oe) |-> sw_age < 4'h4 || o_irq || $past(o_irq);
  endproperty
  a_scl_fall: assert property (p_scl_fall)
    else $error("stretch ended with no cause");
  property p_irq_pulse;
    o_irq |=> !o_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt longer than one cycle");
  // Open-drain lines never driven high
  property p_open_drain;
    !o_scl_o && !o_sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("line driven high");
  property p_ack_hold;
    $rose(o_sda_oe) |=> o_sda_oe [*3];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("data drive too short");
  property p_stretch_hold;
    $rose(o_scl_oe) |=> o_scl_oe [*2];
  endproperty
  a_stretch_hold: assert property (p_stretch_hold)
    else $error("stretch too short");
endmodule // its_slave_properties
bind its_slave its_slave_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_wr(i_wr), .i_rd(i_rd),
  .i_scl(i_scl), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe),
  .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_irq(o_irq));
`default_nettype wire

// file: verification/its_master_model.sv
// Two-wire bus master model on the slave's link
`timescale 1ns/1ps
`default_nettype none
module its_master_model (
  input  wire logic i_scl,
  input  wire logic i_sda,
  output var  logic o_scl_oe,
  output var  logic o_sda_oe
);
  // Both lines released when idle
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end
  // Start: data falls with clock high
  task automatic start;
    o_sda_oe = 1'b0;
    o_scl_oe = 1'b0;
    #400 o_sda_oe = 1'b1;
    #400 o_scl_oe = 1'b1;
  endtask
  // Stop: data rises with clock high
  task automatic stop;
    #50 o_sda_oe = 1'b1;
    #450 o_scl_oe = 1'b0;
    #300 o_sda_oe = 1'b0;
    #400;
  endtask
  // One bit; waits out a stretched clock, bounded
  task automatic bit_io(input logic v, output logic b);
    #50 o_sda_oe = !v;
    #450 o_scl_oe = 1'b0;
    for (int n = 0; n < 400 && !i_scl; n++) #10;
    #300 b = i_sda;
    o_scl_oe = 1'b1;
  endtask
  // Eight bits then the ninth; MSB first
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, k);
  endtask
endmodule // its_master_model
`default_nettype wire

// file: verification/test_its_slave.sv
// Self-checking bench for the two-wire slave
`timescale 1ns/1ps
`default_nettype none
module test_its_slave;
  import its_pkg::*;
  localparam int TK = 8;
  logic       clk;
  logic       rst_b;
  logic       wr;
  logic       rd;
  logic       irq;
  logic       k;
  logic       scl_oe;
  logic       sda_oe;
  logic       m_scl_oe;
  logic       m_sda_oe;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] q;
  wire  logic scl = !(scl_oe | m_scl_oe);
  wire  logic sda = !(sda_oe | m_sda_oe);
  int         err_count = 0;
  int         num_checks = 0;
  int         irqs = 0;
  int         cyc = 0;

  its_slave #(.TICK_CYCLES(TK)) dut (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_scl(scl), .i_sda(sda), .o_scl_o(), .o_scl_oe(scl_oe), .o_sda_o(),
    .o_sda_oe(sda_oe), .o_irq(irq));
  its_master_model m (.i_scl(scl), .i_sda(sda), .o_scl_oe(m_scl_oe),
    .o_sda_oe(m_sda_oe));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Interrupt count and hang ceiling
  always @(posedge clk) begin
    irqs <= irqs + int'(irq === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read, masked compare in the data cycle
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] msk,
                        input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata & msk, e);
  endtask
  // Byte on the link, then six core clocks for the slave to settle
  task automatic mx(input logic [7:0] d, input logic a);
    m.xfer(d, a, q, k);
    repeat (6) @(posedge clk);
  endtask

  task automatic t_reset;
    rd_reg(3'h0, 8'hff, CTL0_POR);
    rd_reg(3'h1, 8'hff, CTL1_POR);
    rd_reg(3'h4, 8'hff, TOC_POR);
    rd_reg(3'h7, 8'hff, 8'h00);
    wr_reg(3'h0, 8'hc2); // Two-wire slave mode on
    wr_reg(3'h3, 8'h5a);
    wr_reg(3'h5, 8'h01);
    $display("setup done");
  endtask
  task automatic t_miss;
    int n;
    n = irqs;
    m.start();
    mx(8'h44, 1'b1);
    chk({7'h00, k}, 8'h01); // Foreign address not acked
    m.stop();
    chk(8'(irqs - n), 8'h00); // No interrupt
    rd_reg(3'h1, 8'h20, 8'h00); // Bus free
    $display("address miss done");
  endtask
  task automatic t_wr;
    int n;
    n = irqs;
    m.start();
    rd_reg(3'h1, 8'ha0, 8'h20); // Busy, byte open
    mx(8'hb4, 1'b1);
    chk({7'h00, k}, 8'h00); // Address acked
    rd_reg(3'h1, 8'hfe, 8'he0); // Match and write
    chk(8'(irqs - n), 8'h01); // One interrupt
    chk({7'h00, scl_oe}, 8'h01); // Clock held
    rd_reg(3'h2, 8'h00, 8'h00);
    mx(8'ha5, 1'b1);
    chk({7'h00, k}, 8'h00); // Data acked
    rd_reg(3'h1, 8'hc0, 8'h80); // Complete, match gone
    rd_reg(3'h2, 8'hff, 8'ha5); // Bit order
    wr_reg(3'h1, 8'h08);
    mx(8'h3c, 1'b1);
    chk({7'h00, k}, 8'h01); // Ack level from bit
    rd_reg(3'h2, 8'hff, 8'h3c);
    m.stop();
    rd_reg(3'h1, 8'ha0, 8'h80); // Free and complete
    wr_reg(3'h1, 8'h00);
    $display("master write done");
  endtask
  task automatic t_rd;
    m.start();
    mx(8'hb5, 1'b1);
    rd_reg(3'h1, 8'he4, 8'he4); // Read request seen
    wr_reg(3'h1, 8'h10); // Transmit direction
    wr_reg(3'h2, 8'h96);
    mx(8'hff, 1'b0);
    chk(q, 8'h96); // Sent MSB first
    rd_reg(3'h1, 8'h81, 8'h80); // Master acked
    wr_reg(3'h2, 8'h41);
    mx(8'hff, 1'b1);
    chk(q, 8'h41); // Last byte
    chk({7'h00, sda_oe}, 8'h00); // Data line let go
    m.stop();
    wr_reg(3'h1, 8'h00);
    $display("master read done");
  endtask
  task automatic t_to;
    int n;
    int c;
    wr_reg(3'h4, 8'h82);
    n = irqs;
    m.start();
    mx(8'hb4, 1'b1);
    rd_reg(3'h2, 8'h00, 8'h00);
    m.xfer(8'h77, 1'b1, q, k);
    chk(8'(irqs - n), 8'h02); // Falls restart the count
    for (c = 0; c < 200 && irqs != n + 3; c++) @(posedge clk);
    chk(8'(c > 2 * TK && c <= 3 * TK + 10), 8'h01); // Period
    rd_reg(3'h4, 8'hff, 8'h42); // Enable off, flag on
    rd_reg(3'h1, 8'hff, CTL1_POR); // Control one reset
    chk({6'h00, scl_oe, sda_oe}, 8'h00); // Lines let go
    rd_reg(3'h3, 8'hff, 8'h5a); // Address kept
    rd_reg(3'h0, 8'hff, 8'hc2); // Mode kept
    m.stop();
    wr_reg(3'h4, 8'h42);
    rd_reg(3'h4, 8'hff, 8'h42); // Writing one keeps flag
    wr_reg(3'h4, 8'h02);
    rd_reg(3'h4, 8'hff, 8'h02); // Writing zero clears
    rd_reg(3'h5, 8'hff, 8'h01); // Interrupt enable kept
    m.start();
    rd_reg(3'h1, 8'ha0, 8'h20); // Busy after start
    wr_reg(3'h0, 8'hc0); // Interface off
    rd_reg(3'h1, 8'ha0, 8'h80); // Flags to defaults when off
    m.stop();
    wr_reg(3'h0, 8'hc2);
    $display("time-out done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_miss();
    t_wr();
    t_rd();
    t_to();
    tally_and_finish();
  end
endmodule // test_its_slave
`default_nettype wire
